// ### src/lpd_cmd_decoder.sv
`timescale 1ns/100ps
module lpd_cmd_decoder #(
	parameter int unsigned BLINK_TICK_CYC = lpd_pkg::LPD_BLINK_TICK_CYC,
	parameter int unsigned FR_HALF_CYC    = lpd_pkg::LPD_FR_HALF_CYC
) (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	// host byte port
	input  wire logic       cmd_wr_i,
	input  wire logic       cmd_data_select_i,
	input  wire logic [7:0] cmd_byte_i,
	// strap pin
	input  wire logic       test_enable_pin_i,
	// settings
	output logic            com_reverse_o,
	output logic            mult_en_o,
	output logic            adj_en_o,
	output logic            follow_en_o,
	output logic [2:0]      res_ratio_o,
	output logic [5:0]      drive_level_o,
	output logic            disp_on_o,
	output logic            all_dots_o,
	output logic            line_inv_o,
	output logic [4:0]      inv_lines_o,
	output logic            ind_on_o,
	output logic [1:0]      ind_mode_o,
	// power state
	output logic            sleep_o,
	output logic            standby_o,
	output logic            osc_run_o,
	output logic            lcd_supply_on_o,
	output logic            drivers_run_o,
	output logic            test_mode_o,
	output logic            cmd_locked_o,
	// indicator pins
	output logic            frame_signal_pin_o,
	output logic            static_indicator_pin_o
);
	import lpd_pkg::*;

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------
	function automatic logic hit(input logic [7:0] b,
		input logic [7:0] val, input logic [7:0] msk);
		hit = ((b & msk) == val);
	endfunction

	lpd_lock_t  lock_reg;
	lpd_psave_t ps_reg;
	logic       cmd_take;
	logic       idle_take;
	logic       test_s1_reg;
	logic       test_s2_reg;

	assign cmd_take  = cmd_wr_i & ~cmd_data_select_i;
	assign idle_take = cmd_take & (lock_reg == LPD_ST_IDLE);

	// ---------------------------------------------------------------
	// test pin synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			test_s1_reg <= 1'b0;
			test_s2_reg <= 1'b0;
		end else begin
			test_s1_reg <= test_enable_pin_i;
			test_s2_reg <= test_s1_reg;
		end
	end

	// ---------------------------------------------------------------
	// lock state machine
	// ---------------------------------------------------------------
	// data bytes never count as the second byte; only command bytes do
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lock_reg <= LPD_ST_IDLE;
		end else if (cmd_take) begin
			case (lock_reg)
			LPD_ST_IDLE: begin
				if (cmd_byte_i == LPD_LVL_MODE)
					lock_reg <= LPD_ST_LVL; // RQ4
				else if (cmd_byte_i == (LPD_IND_VAL | 8'h01))
					lock_reg <= LPD_ST_IND; // RQ8
				else if (cmd_byte_i[7:3] == 5'b11011)
					lock_reg <= LPD_ST_LINES; // RQ12
			end
			LPD_ST_LVL:   lock_reg <= LPD_ST_IDLE; // RQ5
			LPD_ST_IND:   lock_reg <= LPD_ST_IDLE; // RQ8
			LPD_ST_LINES: lock_reg <= LPD_ST_IDLE; // RQ12
			default:      lock_reg <= LPD_ST_IDLE;
			endcase
		end
	end

	assign cmd_locked_o = (lock_reg != LPD_ST_IDLE);

	// ---------------------------------------------------------------
	// common direction, power and ratio
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			com_reverse_o <= 1'b0;
		end else if (idle_take) begin
			if (hit(cmd_byte_i, LPD_COM_VAL, LPD_COM_MSK))
				com_reverse_o <= cmd_byte_i[3]; // RQ1
			else if (cmd_byte_i == LPD_RESET_CMD)
				com_reverse_o <= 1'b0;
		end
	end

	// power enables survive the reset command
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mult_en_o   <= 1'b0;
			adj_en_o    <= 1'b0;
			follow_en_o <= 1'b0;
		end else if (idle_take &&
			hit(cmd_byte_i, LPD_PWR_VAL, LPD_5BIT_MSK)) begin
			mult_en_o   <= cmd_byte_i[2]; // RQ2
			adj_en_o    <= cmd_byte_i[1]; // RQ2
			follow_en_o <= cmd_byte_i[0]; // RQ2
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			res_ratio_o <= LPD_RST_RATIO;
		end else if (idle_take) begin
			if (hit(cmd_byte_i, LPD_RAT_VAL, LPD_5BIT_MSK))
				res_ratio_o <= cmd_byte_i[2:0]; // RQ3
			else if (cmd_byte_i == LPD_RESET_CMD)
				res_ratio_o <= LPD_RST_RATIO;
		end
	end

	// ---------------------------------------------------------------
	// drive level
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			drive_level_o <= LPD_RST_LEVEL;
		end else if (cmd_take && lock_reg == LPD_ST_LVL) begin
			drive_level_o <= cmd_byte_i[5:0]; // RQ5
		end else if (idle_take && cmd_byte_i == LPD_RESET_CMD) begin
			drive_level_o <= LPD_RST_LEVEL;
		end
	end

	// ---------------------------------------------------------------
	// display on/off and all dots
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			disp_on_o  <= 1'b0;
			all_dots_o <= 1'b0;
		end else if (idle_take) begin
			if (hit(cmd_byte_i, LPD_DISP_VAL, LPD_PAIR_MSK))
				disp_on_o <= cmd_byte_i[0];
			if (hit(cmd_byte_i, LPD_ALLON_VAL, LPD_PAIR_MSK))
				all_dots_o <= cmd_byte_i[0]; // RQ22
		end
	end

	// ---------------------------------------------------------------
	// drive method
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			line_inv_o  <= 1'b0;
			inv_lines_o <= LPD_RST_LINES;
		end else if (cmd_take && lock_reg == LPD_ST_LINES) begin
			inv_lines_o <= cmd_byte_i[4:0]; // RQ13
		end else if (idle_take &&
			hit(cmd_byte_i, LPD_DRV_VAL, LPD_COM_MSK)) begin
			line_inv_o <= cmd_byte_i[3]; // RQ11
		end
	end

	// ---------------------------------------------------------------
	// static indicator
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ind_on_o   <= 1'b0;
			ind_mode_o <= LPD_RST_IND;
		end else if (cmd_take && lock_reg == LPD_ST_IND) begin
			ind_mode_o <= cmd_byte_i[1:0]; // RQ9
		end else if (idle_take) begin
			if (hit(cmd_byte_i, LPD_IND_VAL, LPD_PAIR_MSK))
				ind_on_o <= cmd_byte_i[0]; // RQ8
			else if (cmd_byte_i == LPD_RESET_CMD) begin
				ind_on_o   <= 1'b0;
				ind_mode_o <= LPD_RST_IND;
			end
		end
	end

	// ---------------------------------------------------------------
	// power save
	// ---------------------------------------------------------------
	// entry and exit also load all_dots_o from bit 0; every other setting is kept
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ps_reg <= LPD_PS_RUN;
		end else if (idle_take) begin
			if (cmd_byte_i == (LPD_ALLON_VAL | 8'h01)) begin
				if (!disp_on_o && ps_reg == LPD_PS_RUN)
					ps_reg <= ind_on_o ? LPD_PS_STBY
						: LPD_PS_SLEEP; // RQ14 RQ15
			end else if (cmd_byte_i == LPD_ALLON_VAL) begin
				ps_reg <= LPD_PS_RUN; // RQ16
			end else if (cmd_byte_i == LPD_RESET_CMD &&
				ps_reg == LPD_PS_STBY) begin
				ps_reg <= LPD_PS_SLEEP; // RQ19
			end
		end
	end

	assign sleep_o         = (ps_reg == LPD_PS_SLEEP);
	assign standby_o       = (ps_reg == LPD_PS_STBY);
	assign osc_run_o       = !sleep_o; // RQ17
	assign lcd_supply_on_o = (ps_reg == LPD_PS_RUN); // RQ18
	assign drivers_run_o   = (ps_reg == LPD_PS_RUN); // RQ17

	// ---------------------------------------------------------------
	// test mode
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			test_mode_o <= 1'b0;
		end else if (idle_take) begin
			if (hit(cmd_byte_i, LPD_TEST_VAL, LPD_COM_MSK) && test_s2_reg)
				test_mode_o <= 1'b1; // RQ21
			else if (cmd_byte_i == LPD_NOP_CMD ||
				cmd_byte_i == LPD_RESET_CMD)
				test_mode_o <= 1'b0; // RQ20
		end
	end

	// ---------------------------------------------------------------
	// indicator pin drive
	// ---------------------------------------------------------------
	logic       blink_tick;
	logic       fr_tick;
	logic [1:0] blink_cnt_reg;
	logic       ind_lit;

	lpd_ticker #(
		.PERIOD (BLINK_TICK_CYC)
	) u_blink (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (osc_run_o),
		.tick_o    (blink_tick)
	);

	lpd_ticker #(
		.PERIOD (FR_HALF_CYC)
	) u_frame (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.run_i     (osc_run_o),
		.tick_o    (fr_tick)
	);

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			blink_cnt_reg <= 2'h0;
		else if (blink_tick)
			blink_cnt_reg <= blink_cnt_reg + 2'h1;
	end

	// bit 1 toggles every 0.5 s (1 s blink), bit 0 every 0.25 s
	always_comb begin
		case (ind_mode_o)
		2'h1:    ind_lit = blink_cnt_reg[1]; // RQ9
		2'h2:    ind_lit = blink_cnt_reg[0]; // RQ9
		2'h3:    ind_lit = 1'b1;
		default: ind_lit = 1'b0;
		endcase
		ind_lit = ind_lit & ind_on_o; // RQ10
	end

	// pins held low in sleep; an unlit segment sees no dc across it
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_signal_pin_o     <= 1'b0;
			static_indicator_pin_o <= 1'b0;
		end else if (sleep_o) begin
			frame_signal_pin_o     <= 1'b0; // RQ17
			static_indicator_pin_o <= 1'b0; // RQ17
		end else if (fr_tick) begin
			frame_signal_pin_o     <= !frame_signal_pin_o; // RQ18
			static_indicator_pin_o <= !frame_signal_pin_o ^ ind_lit;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	property p_com_dir;
		idle_take && hit(cmd_byte_i, LPD_COM_VAL, LPD_COM_MSK)
			|=> com_reverse_o == $past(cmd_byte_i[3]);
	endproperty
	a_com_dir: assert property (p_com_dir) // RQ1
		else $error("common direction not loaded");

	property p_pwr;
		idle_take && hit(cmd_byte_i, LPD_PWR_VAL, LPD_5BIT_MSK)
			|=> {mult_en_o, adj_en_o, follow_en_o}
				== $past(cmd_byte_i[2:0]);
	endproperty
	a_pwr: assert property (p_pwr) // RQ2
		else $error("power enables not loaded");

	property p_lvl_pair;
		cmd_take && lock_reg == LPD_ST_LVL
			|=> drive_level_o == $past(cmd_byte_i[5:0])
				&& !cmd_locked_o;
	endproperty
	a_lvl_pair: assert property (p_lvl_pair) // RQ5
		else $error("drive level pair failed");

	property p_lock_hold;
		cmd_locked_o |=> $stable(com_reverse_o) && $stable(ps_reg)
			&& $stable(res_ratio_o) && $stable(test_mode_o);
	endproperty
	a_lock_hold: assert property (p_lock_hold) // RQ4
		else $error("command taken while locked");

	property p_ind_steady;
		ind_on_o && ind_mode_o == 2'h3 && !sleep_o && fr_tick
			|=> static_indicator_pin_o != frame_signal_pin_o;
	endproperty
	a_ind_steady: assert property (p_ind_steady) // RQ9
		else $error("steady indicator not lit");

	property p_psave_entry;
		idle_take && cmd_byte_i == (LPD_ALLON_VAL | 8'h01)
			&& !disp_on_o && ps_reg == LPD_PS_RUN
			|=> (standby_o == $past(ind_on_o))
				&& (sleep_o == !$past(ind_on_o));
	endproperty
	a_psave_entry: assert property (p_psave_entry) // RQ14
		else $error("wrong power save state");

	property p_wake;
		idle_take && cmd_byte_i == LPD_ALLON_VAL
			|=> !sleep_o && !standby_o;
	endproperty
	a_wake: assert property (p_wake) // RQ16
		else $error("power save not left");

	property p_sleep_pins;
		sleep_o ##1 sleep_o |-> !frame_signal_pin_o
			&& !static_indicator_pin_o && !drivers_run_o;
	endproperty
	a_sleep_pins: assert property (p_sleep_pins) // RQ17
		else $error("pins driven in sleep");

	property p_stby_reset;
		standby_o && idle_take && cmd_byte_i == LPD_RESET_CMD
			|=> sleep_o;
	endproperty
	a_stby_reset: assert property (p_stby_reset) // RQ19
		else $error("reset in standby missed sleep");

	property p_test_pin;
		$rose(test_mode_o) |-> $past(test_s2_reg);
	endproperty
	a_test_pin: assert property (p_test_pin) // RQ21
		else $error("test mode without pin");

	property p_nop;
		idle_take && cmd_byte_i == LPD_NOP_CMD
			|=> !test_mode_o && $stable(drive_level_o);
	endproperty
	a_nop: assert property (p_nop) // RQ20
		else $error("nop misbehaved");

	c_lines: cover property (idle_take && cmd_byte_i == (LPD_DRV_VAL
		| 8'h08) ##[1:20] !cmd_locked_o);
	c_stby: cover property ($rose(standby_o) ##[1:50] !standby_o);
	c_sleep: cover property ($rose(sleep_o));
	c_ind: cover property ($rose(static_indicator_pin_o ^
		frame_signal_pin_o));

endmodule

// ### src/lpd_pkg.sv
// Summary of operation
// RQ1: byte 1100xxxx sets common scan direction from bit 3.
// RQ2: byte 00101xxx loads multiplier, adjuster and follower enables.
// RQ3: byte 00100xxx stores three-bit resistor ratio.
// RQ4: drive-level mode byte locks decoder until the value byte.
// RQ5: value byte loads six low bits as drive level, releases lock.
// RQ6: host sends mode byte and value byte back to back.
// RQ7: unused adjustment advises value code 100000.
// RQ8: indicator byte acts on bit 0; on form locks until register byte.
// RQ9: indicator register keeps two bits: off, 1 s, 0.5 s, steady.
// RQ10: indicator pins follow only the indicator commands.
// RQ11: byte 1101xxxx picks frame or line inversion from bit 3.
// RQ12: line inversion locks decoder until the line count byte.
// RQ13: count byte low five bits give n plus one lines.
// RQ14: all-dots-on while display off enters standby or sleep.
// RQ15: power save keeps all settings and still serves memory access.
// RQ16: all-dots-on off command leaves power save.
// RQ17: sleep stops oscillator, supply and drivers; outputs at ground.
// RQ18: standby stops supply and dynamic drivers; indicator keeps running.
// RQ19: reset command in standby moves to sleep.
// RQ20: byte 11100011 changes nothing except releasing test mode.
// RQ21: byte 1111xxxx enters test mode only with test pin high.
// RQ22: byte 1010010x sets all dots on or normal display.
package lpd_pkg;

	// ---------------------------------------------------------------
	// command codes and masks
	// ---------------------------------------------------------------
	localparam logic [7:0] LPD_COM_VAL   = 8'hc0;
	localparam logic [7:0] LPD_COM_MSK   = 8'hf0;
	localparam logic [7:0] LPD_PWR_VAL   = 8'h28;
	localparam logic [7:0] LPD_RAT_VAL   = 8'h20;
	localparam logic [7:0] LPD_5BIT_MSK  = 8'hf8;
	localparam logic [7:0] LPD_LVL_MODE  = 8'h81;
	localparam logic [7:0] LPD_IND_VAL   = 8'hac;
	localparam logic [7:0] LPD_ALLON_VAL = 8'ha4;
	localparam logic [7:0] LPD_DISP_VAL  = 8'hae;
	localparam logic [7:0] LPD_PAIR_MSK  = 8'hfe;
	localparam logic [7:0] LPD_DRV_VAL   = 8'hd0;
	localparam logic [7:0] LPD_RESET_CMD = 8'he2;
	localparam logic [7:0] LPD_NOP_CMD   = 8'he3;
	localparam logic [7:0] LPD_TEST_VAL  = 8'hf0;

	// ---------------------------------------------------------------
	// values after reset
	// ---------------------------------------------------------------
	localparam logic [5:0] LPD_RST_LEVEL = 6'h20;
	localparam logic [2:0] LPD_RST_RATIO = 3'h0;
	localparam logic [1:0] LPD_RST_IND   = 2'h0;
	localparam logic [4:0] LPD_RST_LINES = 5'h00;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned LPD_CLK_HZ       = 10_000_000;
	localparam int unsigned LPD_BLINK_TICK_MS = 250;
	localparam int unsigned LPD_BLINK_TICK_CYC =
		LPD_CLK_HZ / 1000 * LPD_BLINK_TICK_MS;
	localparam int unsigned LPD_FR_HALF_US   = 8;
	localparam int unsigned LPD_FR_HALF_CYC  =
		LPD_CLK_HZ / 1_000_000 * LPD_FR_HALF_US;

	// ---------------------------------------------------------------
	// decoder lock states, gray along idle->lock->idle for LVL and LINES only
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		LPD_ST_IDLE  = 2'b00,
		LPD_ST_LVL   = 2'b01,
		LPD_ST_IND   = 2'b11,
		LPD_ST_LINES = 2'b10
	} lpd_lock_t;

	typedef enum logic [1:0] {
		LPD_PS_RUN   = 2'b00,
		LPD_PS_STBY  = 2'b01,
		LPD_PS_SLEEP = 2'b11
	} lpd_psave_t;

endpackage

// ### src/lpd_ticker.sv
`timescale 1ns/100ps
module lpd_ticker #(
	parameter int unsigned PERIOD = 80
) (
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic sys_rst_i,
	// control
	input  wire logic run_i,
	output logic      tick_o
);
	import lpd_pkg::*;

	localparam int unsigned CW = (PERIOD > 2) ? $clog2(PERIOD) : 1;
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

	logic [CW-1:0] cnt_reg;

	// counter restarts when stopped so the first tick is a full period
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end else if (!run_i) begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= '0;
			tick_o  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick_o  <= 1'b0;
		end
	end

endmodule

// ### tb/lpd_host_model.sv
`timescale 1ns/100ps
module lpd_host_model (
	// clock
	input  wire logic       mclk_i,
	// host byte port
	output logic            cmd_wr_o,
	output logic            cmd_data_select_o,
	output logic [7:0]      cmd_byte_o
);
	import lpd_pkg::*;

	// ---------------------------------------------------------------
	// byte writer
	// ---------------------------------------------------------------
	// mid-scale level for a host that skips drive adjustment
	localparam logic [7:0] LPD_LVL_UNUSED = 8'h20;

	initial begin
		cmd_wr_o          = 1'b0;
		cmd_data_select_o = 1'b0;
		cmd_byte_o        = 8'h00;
	end

	// caller sits at a falling edge; one byte per cycle
	task automatic put(input logic sel, input logic [7:0] b);
		cmd_wr_o          = 1'b1;
		cmd_data_select_o = sel;
		cmd_byte_o        = b;
		@(negedge mclk_i);
	endtask

	// idle bus shows the inverse, so a stale byte is never reused;
	// one idle cycle keeps the strobe from dropping and rising at once
	task automatic rest();
		cmd_wr_o   = 1'b0;
		cmd_byte_o = ~cmd_byte_o;
		@(negedge mclk_i);
	endtask

	task automatic cmd(input logic [7:0] b);
		put(1'b0, b);
		rest();
	endtask

	// mode byte and value byte leave back to back
	task automatic pair(input logic [7:0] a, input logic [7:0] b);
		put(1'b0, a);
		put(1'b0, b);
		rest();
	endtask

	task automatic skip_level();
		pair(LPD_LVL_MODE, LPD_LVL_UNUSED);
	endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import lpd_pkg::*;
	localparam int unsigned BLINK = 8;
	localparam int unsigned FRH   = 4;
	localparam int          WD_NS = 200_000;

	logic       mclk_i;
	logic       sys_rst_i;
	logic       test_enable_pin_i;
	logic       cmd_wr_i;
	logic       cmd_data_select_i;
	logic [7:0] cmd_byte_i;
	logic       com_reverse_o;
	logic       mult_en_o;
	logic       adj_en_o;
	logic       follow_en_o;
	logic [2:0] res_ratio_o;
	logic [5:0] drive_level_o;
	logic       disp_on_o;
	logic       all_dots_o;
	logic       line_inv_o;
	logic       ind_on_o;
	logic [4:0] inv_lines_o;
	logic [1:0] ind_mode_o;
	logic       sleep_o;
	logic       standby_o;
	logic       osc_run_o;
	logic       lcd_supply_on_o;
	logic       drivers_run_o;
	logic       test_mode_o;
	logic       cmd_locked_o;
	logic       frame_signal_pin_o;
	logic       static_indicator_pin_o;
	int         err_total = 0;
	int         compares = 0;

	initial mclk_i = 1'b0;
	always #50 mclk_i = ~mclk_i;

	lpd_host_model u_lpd_host_model (
		.mclk_i            (mclk_i),
		.cmd_wr_o          (cmd_wr_i),
		.cmd_data_select_o (cmd_data_select_i),
		.cmd_byte_o        (cmd_byte_i)
	);

	lpd_cmd_decoder #(.BLINK_TICK_CYC(BLINK), .FR_HALF_CYC(FRH))
	u_lpd_cmd_decoder (
		.mclk_i                 (mclk_i),
		.sys_rst_i              (sys_rst_i),
		.cmd_wr_i               (cmd_wr_i),
		.cmd_data_select_i      (cmd_data_select_i),
		.cmd_byte_i             (cmd_byte_i),
		.test_enable_pin_i      (test_enable_pin_i),
		.com_reverse_o          (com_reverse_o),
		.mult_en_o              (mult_en_o),
		.adj_en_o               (adj_en_o),
		.follow_en_o            (follow_en_o),
		.res_ratio_o            (res_ratio_o),
		.drive_level_o          (drive_level_o),
		.disp_on_o              (disp_on_o),
		.all_dots_o             (all_dots_o),
		.line_inv_o             (line_inv_o),
		.inv_lines_o            (inv_lines_o),
		.ind_on_o               (ind_on_o),
		.ind_mode_o             (ind_mode_o),
		.sleep_o                (sleep_o),
		.standby_o              (standby_o),
		.osc_run_o              (osc_run_o),
		.lcd_supply_on_o        (lcd_supply_on_o),
		.drivers_run_o          (drivers_run_o),
		.test_mode_o            (test_mode_o),
		.cmd_locked_o           (cmd_locked_o),
		.frame_signal_pin_o     (frame_signal_pin_o),
		.static_indicator_pin_o (static_indicator_pin_o)
	);

	// ---------------------------------------------------------------
	// checking and closing
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e,
			input logic [7:0] g);
		compares++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// m 0: pins alike, 1: pins opposite, 2: both held low and still
	task automatic pins(input int m, input string n);
		int   flips;
		logic last;
		flips = 0;
		// the static pin only follows a change at the next frame tick
		repeat (FRH) @(negedge mclk_i);
		last = frame_signal_pin_o;
		repeat (3 * FRH) begin
			@(negedge mclk_i);
			if (frame_signal_pin_o !== last) flips++;
			last = frame_signal_pin_o;
			if (m == 2) chk(n, 8'h00, 8'(frame_signal_pin_o));
			chk(n, (m == 2) ? 8'h00 : 8'(last ^ logic'(m == 1)),
				8'(static_indicator_pin_o));
		end
		chk(n, 8'(m != 2), 8'(flips != 0));
	endtask

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		sys_rst_i = 1'b1;
		test_enable_pin_i = 1'b0;
		repeat (16) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		@(negedge mclk_i);
		chk("level_rst", 8'h20, 8'(drive_level_o));
		chk("osc_rst", 8'h01, 8'(osc_run_o));
		$display("test reset done");
		u_lpd_host_model.cmd(8'hc8);
		chk("com_rev", 8'h01, 8'(com_reverse_o));
		u_lpd_host_model.put(1'b1, 8'hc0);
		u_lpd_host_model.rest();
		chk("com_data", 8'h01, 8'(com_reverse_o));
		u_lpd_host_model.cmd(8'hc7);
		chk("com_fwd", 8'h00, 8'(com_reverse_o));
		for (int i = 0; i < 8; i++) begin
			u_lpd_host_model.cmd(8'h28 | 8'(i));
			chk("power", 8'(i), 8'({mult_en_o, adj_en_o, follow_en_o}));
			u_lpd_host_model.cmd(8'h20 | 8'(i));
			chk("ratio", 8'(i), 8'(res_ratio_o));
		end
		$display("test settings done");
		u_lpd_host_model.put(1'b0, 8'h81);
		chk("lvl_lock", 8'h01, 8'(cmd_locked_o));
		u_lpd_host_model.put(1'b0, 8'hc8);
		u_lpd_host_model.rest();
		chk("lvl_val", 8'h08, 8'(drive_level_o));
		chk("lvl_com", 8'h00, 8'(com_reverse_o));
		chk("lvl_free", 8'h00, 8'(cmd_locked_o));
		u_lpd_host_model.put(1'b0, 8'h81);
		u_lpd_host_model.put(1'b1, 8'h11);
		chk("lvl_data", 8'h01, 8'(cmd_locked_o));
		u_lpd_host_model.put(1'b0, 8'hff);
		u_lpd_host_model.rest();
		chk("lvl_max", 8'h3f, 8'(drive_level_o));
		u_lpd_host_model.skip_level();
		chk("lvl_mid", 8'h20, 8'(drive_level_o));
		$display("test level done");
		for (int m = 0; m < 4; m++) begin
			u_lpd_host_model.pair(8'had, 8'hfc | 8'(m));
			chk("ind_on", 8'h01, 8'(ind_on_o));
			chk("ind_mode", 8'(m), 8'(ind_mode_o));
		end
		u_lpd_host_model.put(1'b0, 8'had);
		chk("ind_lock", 8'h01, 8'(cmd_locked_o));
		u_lpd_host_model.put(1'b0, 8'haf);
		u_lpd_host_model.rest();
		chk("ind_disp", 8'h00, 8'(disp_on_o));
		chk("ind_steady", 8'h03, 8'(ind_mode_o));
		pins(1, "lit");
		u_lpd_host_model.cmd(8'ha7);
		pins(1, "lit_other");
		u_lpd_host_model.cmd(8'hac);
		chk("ind_off", 8'h00, 8'(ind_on_o));
		pins(0, "unlit");
		$display("test indicator done");
		u_lpd_host_model.cmd(8'hd7);
		chk("frame_inv", 8'h00, 8'(line_inv_o));
		u_lpd_host_model.put(1'b0, 8'hdf);
		chk("line_lock", 8'h01, 8'(cmd_locked_o));
		u_lpd_host_model.put(1'b0, 8'he0);
		u_lpd_host_model.rest();
		chk("lines_min", 8'h00, 8'(inv_lines_o));
		chk("line_free", 8'h00, 8'(cmd_locked_o));
		chk("line_inv", 8'h01, 8'(line_inv_o));
		u_lpd_host_model.pair(8'hd8, 8'hff);
		chk("lines_max", 8'h1f, 8'(inv_lines_o));
		u_lpd_host_model.cmd(8'hd0);
		chk("frame_back", 8'h00, 8'(line_inv_o));
		$display("test inversion done");
		u_lpd_host_model.cmd(8'hc8);
		u_lpd_host_model.cmd(8'h25);
		u_lpd_host_model.pair(8'h81, 8'h15);
		u_lpd_host_model.cmd(8'ha5);
		chk("sleep", 8'h01, 8'({standby_o, sleep_o}));
		chk("sleep_run", 8'h00,
			8'({osc_run_o, lcd_supply_on_o, drivers_run_o}));
		@(negedge mclk_i);
		pins(2, "sleep_pins");
		chk("keep", 8'hd5, {com_reverse_o, res_ratio_o[0], drive_level_o});
		chk("keep_r", 8'h05, 8'(res_ratio_o));
		u_lpd_host_model.cmd(8'ha4);
		chk("wake", 8'h07,
			8'({osc_run_o, lcd_supply_on_o, drivers_run_o}));
		u_lpd_host_model.pair(8'had, 8'h03);
		u_lpd_host_model.cmd(8'ha5);
		chk("stby", 8'h02, 8'({standby_o, sleep_o}));
		chk("stby_run", 8'h04,
			8'({osc_run_o, lcd_supply_on_o, drivers_run_o}));
		pins(1, "stby_pins");
		u_lpd_host_model.cmd(8'he2);
		chk("stby_rst", 8'h01, 8'({standby_o, sleep_o}));
		u_lpd_host_model.cmd(8'ha4);
		chk("wake2", 8'h00, 8'({standby_o, sleep_o}));
		u_lpd_host_model.cmd(8'haf);
		u_lpd_host_model.cmd(8'ha5);
		chk("all_on", 8'h01, 8'({sleep_o, all_dots_o}));
		u_lpd_host_model.cmd(8'ha4);
		chk("all_off", 8'h00, 8'(all_dots_o));
		u_lpd_host_model.cmd(8'hae);
		$display("test power save done");
		u_lpd_host_model.cmd(8'hf0);
		chk("test_low", 8'h00, 8'(test_mode_o));
		test_enable_pin_i = 1'b1;
		repeat (3) @(negedge mclk_i);
		u_lpd_host_model.cmd(8'hc8);
		u_lpd_host_model.cmd(8'hf5);
		chk("test_high", 8'h01, 8'(test_mode_o));
		u_lpd_host_model.cmd(8'he3);
		chk("nop_test", 8'h00, 8'(test_mode_o));
		chk("nop_keep", 8'h01, 8'(com_reverse_o));
		test_enable_pin_i = 1'b0;
		$display("test test mode done");
		stop_test();
	end

	initial begin
		#(WD_NS);
		err_total++;
		$display("BAD watchdog expected done seen hang");
		stop_test();
	end
endmodule
